// >>> design/clock_switch_pkg.sv
// Constants, register map and types shared by the clock switch design
package clock_switch_pkg;

  // ----------------------------------------------------------------
  // Source codes and oscillator indices
  // ----------------------------------------------------------------
  localparam logic [7:0] CODE_FAST_INT = 8'he1;
  localparam logic [7:0] CODE_SLOW_INT = 8'h5a;
  localparam logic [7:0] CODE_FAST_EXT = 8'ha5;
  localparam logic [7:0] CODE_RESET = CODE_FAST_INT;
  localparam int OSC_COUNT = 3;
  localparam logic [1:0] OSC_FAST_INT = 2'h0;
  localparam logic [1:0] OSC_SLOW_INT = 2'h1;
  localparam logic [1:0] OSC_FAST_EXT = 2'h2;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SWITCH_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SWITCH_REQ = 8'h04;
  localparam logic [7:0] ADDR_MASTER_STATUS = 8'h08;
  localparam logic [7:0] ADDR_INT_OSC = 8'h0c;
  localparam logic [7:0] ADDR_EXT_OSC = 8'h10;
  localparam logic [7:0] ADDR_PCK_FIRST = 8'h14;
  localparam logic [7:0] ADDR_PCK_SECOND = 8'h18;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int SWC_BUSY_BIT = 0;
  localparam int SWC_EXEC_BIT = 1;
  localparam int SWC_IRQEN_BIT = 2;
  localparam int SWC_DONE_BIT = 3;
  localparam int EXT_AWU_SEL_BIT = 2;
  localparam logic [7:0] OSC_CTRL_ADDR [OSC_COUNT] = '{ADDR_INT_OSC, ADDR_INT_OSC, ADDR_EXT_OSC};
  localparam int OSC_EN_BIT [OSC_COUNT] = '{0, 2, 0};
  localparam logic [OSC_COUNT-1:0] OSC_EN_RESET = 3'h1;
  localparam int PERIPH_COUNT = 13;
  localparam logic [7:0] PCK_FIRST_RESET = 8'h7f;
  localparam logic [7:0] PCK_SECOND_RESET = 8'h3f;

  // ----------------------------------------------------------------
  // Timing counts, in oscillator ticks
  // ----------------------------------------------------------------
  localparam logic [11:0] STAB_FAST_INT = 12'h002;
  localparam logic [11:0] STAB_SLOW_INT = 12'h000;
  // Half a cycle is rounded up to one whole tick
  localparam logic [11:0] STAB_EXT [4] = '{12'h001, 12'h008, 12'h080, 12'h800};
  localparam logic [0:0] SWITCH_LATENCY_TICKS = 1'h1;
  localparam logic [3:0] AWU_EXT_DIV_LAST = 4'hf;

  typedef enum logic [1:0] {sw_idle, sw_wait_ready, sw_wait_exec, sw_switching} switch_state_type;

endpackage

// >>> design/sync_two_stage.sv
// Two flip-flop synchroniser for a group of levels
`timescale 1ns/1ns
module sync_two_stage
  import clock_switch_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stage1_q <= '0;
      dout <= '0;
    end
    else
    begin
      stage1_q <= din;
      dout <= stage1_q;
    end
  end

endmodule

// >>> design/clock_glitch_mux.sv
// Glitch-free master tick selector with new-source filtering
`timescale 1ns/1ns
module clock_glitch_mux
  import clock_switch_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [OSC_COUNT-1:0] src_tick,
  input wire logic start,
  input wire logic abort,
  input wire logic [1:0] new_sel,
  output logic master_tick_q,
  output logic done_q
);

  logic [1:0] active_q;
  logic [1:0] new_q;
  logic pending_q;
  logic [0:0] seen_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      active_q <= OSC_FAST_INT;
      new_q <= OSC_FAST_INT;
      pending_q <= 1'b0;
      seen_q <= '0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (abort)
      begin
        pending_q <= 1'b0;
      end
      else if (start)
      begin
        pending_q <= 1'b1;
        new_q <= new_sel;
        seen_q <= '0;
      end
      else if (pending_q && src_tick[new_q])
      begin
        if (seen_q == SWITCH_LATENCY_TICKS)
        begin
          active_q <= new_q;
          pending_q <= 1'b0;
          done_q <= 1'b1;
        end
        else
        begin
          seen_q <= seen_q + 1'b1;
        end
      end
    end
  end

  // Old ticks pass until the new source is seen; then low phase stretches
  always_ff @(posedge clk)
  begin
    if (rst)
      master_tick_q <= 1'b0;
    else
      master_tick_q <= src_tick[active_q] && !(pending_q && seen_q != '0);
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_switch_bound: assert property (pending_q && !abort && !start && src_tick[new_q] &&
    seen_q == SWITCH_LATENCY_TICKS |=> done_q && !pending_q)
    else $error("switch not completed on second new tick");
  a_old_kept: assert property (pending_q && seen_q == '0 && src_tick[active_q] |=> master_tick_q)
    else $error("old source dropped before new source seen");

endmodule

// >>> design/master_clock_switch_gating.sv
// Master clock switch controller with peripheral tick gating and APB registers
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ns
module master_clock_switch_gating
  import clock_switch_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic osc_fast_int_in,
  input wire logic osc_slow_int_in,
  input wire logic osc_fast_ext_in,
  input wire logic ext_clock_mode,
  input wire logic [1:0] ext_stab_sel,
  output logic master_tick,
  output logic icu_tick,
  output logic [PERIPH_COUNT-1:0] periph_tick,
  output logic awu_tick,
  output logic switch_irq
);

  // ----------------------------------------------------------------
  // Oscillator inputs and tick detection
  // ----------------------------------------------------------------
  logic [OSC_COUNT-1:0] osc_sync;
  logic [OSC_COUNT-1:0] osc_prev_q;
  logic [OSC_COUNT-1:0] tick;
  logic [2:0] strap_sync;

  // Straps are pins too, so they share the oscillator synchroniser
  sync_two_stage #(.WIDTH(OSC_COUNT + 3)) u_osc_sync
  (
    .clk(clk),
    .rst(rst),
    .din({ext_stab_sel, ext_clock_mode, osc_fast_ext_in, osc_slow_int_in, osc_fast_int_in}),
    .dout({strap_sync, osc_sync})
  );

  always_ff @(posedge clk)
  begin
    if (rst)
      osc_prev_q <= '0;
    else
      osc_prev_q <= osc_sync;
  end

  assign tick = osc_sync & ~osc_prev_q;

  function automatic logic valid_code(input logic [7:0] code);
    valid_code = (code == CODE_FAST_INT) || (code == CODE_SLOW_INT) || (code == CODE_FAST_EXT);
  endfunction

  function automatic logic [1:0] osc_of(input logic [7:0] code);
    if (code == CODE_SLOW_INT)
      osc_of = OSC_SLOW_INT;
    else if (code == CODE_FAST_EXT)
      osc_of = OSC_FAST_EXT;
    else
      osc_of = OSC_FAST_INT;
  endfunction

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic wr;
  logic abort;
  logic [7:0] req_q;
  logic [7:0] status_q;
  logic busy_q;
  logic exec_q;
  logic irqen_q;
  logic done_q;
  logic awu_ext_q;
  logic [OSC_COUNT-1:0] en_q;
  logic [OSC_COUNT-1:0] rdy;
  logic [7:0] pck_first_q;
  logic [7:0] pck_second_q;
  switch_state_type state_q;
  logic [1:0] tgt_idx;
  logic go_start;
  logic go_manual;
  logic finish;
  logic start_q;
  logic mux_done;
  logic mux_tick;

  assign wr = psel && penable && pwrite && pready;
  // Only a real clear of a set flag aborts; writing one is a no-op
  assign abort = wr && paddr == ADDR_SWITCH_CTRL && !pwdata[SWC_BUSY_BIT] && busy_q;
  assign tgt_idx = osc_of(req_q);
  assign go_start = !abort && exec_q && rdy[tgt_idx] &&
    (state_q == sw_wait_ready || state_q == sw_wait_exec);
  assign go_manual = !abort && !exec_q && rdy[tgt_idx] && state_q == sw_wait_ready;
  assign finish = !abort && state_q == sw_switching && mux_done;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
    else if (psel && !penable)
    begin
      pready <= 1'b1;
      pslverr <= 1'b0;
      case (paddr)
        ADDR_SWITCH_CTRL: prdata <= {28'h0, done_q, irqen_q, exec_q, busy_q};
        ADDR_SWITCH_REQ: prdata <= {24'h0, req_q};
        ADDR_MASTER_STATUS: prdata <= {24'h0, status_q};
        ADDR_INT_OSC: prdata <= {28'h0, rdy[1], en_q[1], rdy[0], en_q[0]};
        ADDR_EXT_OSC: prdata <= {29'h0, awu_ext_q, rdy[2], en_q[2]};
        ADDR_PCK_FIRST: prdata <= {24'h0, pck_first_q};
        ADDR_PCK_SECOND: prdata <= {24'h0, pck_second_q};
        default:
        begin
          prdata <= '0;
          pslverr <= 1'b1;
        end
      endcase
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Switch sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      req_q <= CODE_RESET;
      status_q <= CODE_RESET;
      busy_q <= 1'b0;
      state_q <= sw_idle;
      start_q <= 1'b0;
    end
    else
    begin
      start_q <= go_start;
      if (abort)
      begin
        req_q <= status_q;
        busy_q <= 1'b0;
        state_q <= sw_idle;
      end
      else
      begin
        case (state_q)
          sw_idle:
          begin
            // Unknown codes are dropped rather than stalling the sequencer
            if (wr && paddr == ADDR_SWITCH_REQ && !busy_q && valid_code(pwdata[7:0]))
              req_q <= pwdata[7:0];
            if (req_q != status_q)
            begin
              busy_q <= 1'b1;
              state_q <= sw_wait_ready;
            end
          end
          sw_wait_ready:
          begin
            if (go_start)
              state_q <= sw_switching;
            else if (go_manual)
              state_q <= sw_wait_exec;
          end
          sw_wait_exec:
          begin
            if (go_start)
              state_q <= sw_switching;
          end
          sw_switching:
          begin
            if (finish)
            begin
              status_q <= req_q;
              busy_q <= 1'b0;
              state_q <= sw_idle;
            end
          end
          default: state_q <= sw_idle;
        endcase
      end
    end
  end

  clock_glitch_mux u_mux
  (
    .clk(clk),
    .rst(rst),
    .src_tick(tick),
    .start(start_q),
    .abort(abort),
    .new_sel(tgt_idx),
    .master_tick_q(mux_tick),
    .done_q(mux_done)
  );

  // ----------------------------------------------------------------
  // Control and flag bits
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      exec_q <= 1'b0;
      irqen_q <= 1'b0;
      awu_ext_q <= 1'b0;
    end
    else
    begin
      if (wr && paddr == ADDR_SWITCH_CTRL)
      begin
        exec_q <= pwdata[SWC_EXEC_BIT];
        irqen_q <= pwdata[SWC_IRQEN_BIT];
      end
      if (wr && paddr == ADDR_EXT_OSC)
        awu_ext_q <= pwdata[EXT_AWU_SEL_BIT];
    end
  end

  // Done flag: writing zero clears it, a same-cycle set still wins
  always_ff @(posedge clk)
  begin
    if (rst)
      done_q <= 1'b0;
    else if (go_manual || finish)
      done_q <= 1'b1;
    else if (wr && paddr == ADDR_SWITCH_CTRL && !pwdata[SWC_DONE_BIT])
      done_q <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      switch_irq <= 1'b0;
    else
      switch_irq <= done_q && irqen_q;
  end

  // ----------------------------------------------------------------
  // Oscillator enables and stabilisation
  // ----------------------------------------------------------------
  logic [11:0] stab_limit [OSC_COUNT];
  logic [11:0] stab_cnt_q [OSC_COUNT];

  assign stab_limit[0] = STAB_FAST_INT;
  assign stab_limit[1] = STAB_SLOW_INT;
  assign stab_limit[2] = strap_sync[0] ? 12'h000 : STAB_EXT[strap_sync[2:1]];

  for (genvar i = 0; i < OSC_COUNT; i++)
  begin : g_osc
    // Hardware only ever turns a source on; switching off is software's job
    always_ff @(posedge clk)
    begin
      if (rst)
        en_q[i] <= OSC_EN_RESET[i];
      else if (busy_q && tgt_idx == 2'(i))
        en_q[i] <= 1'b1;
      else if (wr && paddr == OSC_CTRL_ADDR[i])
        en_q[i] <= pwdata[OSC_EN_BIT[i]];
    end

    always_ff @(posedge clk)
    begin
      if (rst || !en_q[i])
        stab_cnt_q[i] <= '0;
      else if (tick[i] && stab_cnt_q[i] < stab_limit[i])
        stab_cnt_q[i] <= stab_cnt_q[i] + 12'h001;
    end

    assign rdy[i] = en_q[i] && stab_cnt_q[i] >= stab_limit[i];
  end

  // ----------------------------------------------------------------
  // Peripheral gating and wake-up tick
  // ----------------------------------------------------------------
  logic [PERIPH_COUNT-1:0] gate_sync;
  logic [3:0] awu_div_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pck_first_q <= PCK_FIRST_RESET;
      pck_second_q <= PCK_SECOND_RESET;
    end
    else if (wr && paddr == ADDR_PCK_FIRST)
      pck_first_q <= pwdata[7:0] & PCK_FIRST_RESET;
    else if (wr && paddr == ADDR_PCK_SECOND)
      pck_second_q <= pwdata[7:0] & PCK_SECOND_RESET;
  end

  // Enables are restaged so a gate edge never splits a tick
  sync_two_stage #(.WIDTH(PERIPH_COUNT)) u_gate_sync
  (
    .clk(clk),
    .rst(rst),
    .din({pck_second_q[5:0], pck_first_q[6:0]}),
    .dout(gate_sync)
  );

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      master_tick <= 1'b0;
      icu_tick <= 1'b0;
      periph_tick <= '0;
    end
    else
    begin
      master_tick <= mux_tick;
      icu_tick <= mux_tick;
      periph_tick <= {PERIPH_COUNT{mux_tick}} & gate_sync;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      awu_div_q <= '0;
      awu_tick <= 1'b0;
    end
    else
    begin
      if (tick[OSC_FAST_EXT])
        awu_div_q <= awu_div_q + 4'h1;
      if (awu_ext_q)
        awu_tick <= tick[OSC_FAST_EXT] && awu_div_q == AWU_EXT_DIV_LAST;
      else
        awu_tick <= tick[OSC_SLOW_INT];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_ready_exec;
    (state_q == sw_wait_ready || state_q == sw_wait_exec) && exec_q && rdy[tgt_idx] && !abort;
  endsequence

  a_busy_on_diff: assert property (state_q == sw_idle && req_q != status_q && !abort |=> busy_q)
    else $error("busy not raised on differing request");
  a_req_frozen: assert property (busy_q && !abort && state_q != sw_idle |=> $stable(req_q))
    else $error("request changed while busy");
  a_abort_restore: assert property (abort |=> !busy_q && req_q == $past(status_q) &&
    state_q == sw_idle)
    else $error("abort did not restore request");
  a_abort_wins: assert property (abort && pwdata[SWC_EXEC_BIT] |=> !start_q ##1 !busy_q)
    else $error("switch started despite abort");
  a_exec_start: assert property (s_ready_exec |=> start_q && state_q == sw_switching)
    else $error("ready switch did not start");
  a_no_exec_hold: assert property (state_q == sw_wait_exec && !exec_q |=> state_q != sw_switching)
    else $error("switch executed without enable");
  a_done_flag: assert property (go_manual || finish |=> done_q ##1 (switch_irq == irqen_q))
    else $error("done flag or interrupt missing");
  a_old_powered: assert property (finish && !wr |=> (en_q & $past(en_q)) == $past(en_q))
    else $error("old source powered down by hardware");
  a_icu_ungated: assert property (icu_tick == $past(mux_tick))
    else $error("interrupt controller tick gated");
  a_finish_status: assert property (finish |=> status_q == $past(req_q) && !busy_q)
    else $error("status not updated at switch end");

endmodule

// >>> tb/testbench.sv
// Self-checking testbench for the master clock switch and peripheral gating block
`timescale 1ns/1ns
module testbench
  import clock_switch_pkg::*;
;
  localparam logic [31:0] F_BUSY = 32'h1 << SWC_BUSY_BIT;
  localparam logic [31:0] F_EXEC = 32'h1 << SWC_EXEC_BIT;
  localparam logic [31:0] F_IRQEN = 32'h1 << SWC_IRQEN_BIT;
  localparam logic [31:0] F_DONE = 32'h1 << SWC_DONE_BIT;
  logic clk, rst, psel, penable, pwrite, chk, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_data, v;
  logic osc_fi, osc_si, osc_fe, ext_clock_mode;
  logic [1:0] ext_stab_sel;
  logic master_tick, icu_tick, awu_tick, switch_irq;
  logic [PERIPH_COUNT-1:0] periph_tick;
  logic [32:0] exp_q[$];
  int failures, tests_run, seed;

  master_clock_switch_gating u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .osc_fast_int_in(osc_fi), .osc_slow_int_in(osc_si),
    .osc_fast_ext_in(osc_fe), .ext_clock_mode(ext_clock_mode), .ext_stab_sel(ext_stab_sel),
    .master_tick(master_tick), .icu_tick(icu_tick), .periph_tick(periph_tick),
    .awu_tick(awu_tick), .switch_irq(switch_irq));

  // ----------------------------------------
  // Clock and free-running oscillators
  // ----------------------------------------
  // Oscillators are unrelated to clk; periods 60, 200 and 100 ns keep highs above two cycles
  initial begin clk = 1'b0; forever #5 clk = ~clk; end
  initial begin osc_fi = 1'b0; forever #30 osc_fi = ~osc_fi; end
  initial begin osc_si = 1'b0; #7; forever #100 osc_si = ~osc_si; end
  initial begin osc_fe = 1'b0; #13; forever #50 osc_fe = ~osc_fe; end

  // ----------------------------------------
  // Compare tasks and report
  // ----------------------------------------
  task automatic check_bus(input logic [32:0] got, input logic [32:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_cnt(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("Comparisons: %0d, mismatches: %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Read results are matched in order against the notes left by the driver
  always @(posedge clk)
  begin
    if (psel && penable && pready === 1'b1 && chk && exp_q.size() > 0)
      check_bus({pslverr, prdata}, exp_q.pop_front());
  end

  // ----------------------------------------
  // APB master
  // ----------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    chk <= c;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      failures++;
      final_report();
    end
    else
    begin
      rd_data = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      chk <= 1'b0;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err = 1'b0);
    exp_q.push_back({err, e});
    apb(1'b0, a, 32'h0, 1'b1);
  endtask

  // Bounded wait on a register field; running out counts as a mismatch
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] val);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, a, 32'h0, 1'b0);
      n++;
    end
    while ((rd_data & m) !== val && n < 400);
    if ((rd_data & m) !== val)
    begin
      failures++;
      final_report();
    end
  endtask

  // Window aligned to a source edge so that each source tick gives exactly one pulse
  task automatic count_ticks(input logic ext, input logic [PERIPH_COUNT-1:0] en);
    int n, mt, ic, aw;
    int pc[PERIPH_COUNT];
    n = ext ? 20 : 10;
    mt = 0;
    ic = 0;
    aw = 0;
    foreach (pc[i]) pc[i] = 0;
    if (ext) @(posedge osc_fe);
    else @(posedge osc_si);
    repeat (ext ? 8 : 10) @(posedge clk);
    repeat (200)
    begin
      @(posedge clk);
      mt += (master_tick === 1'b1);
      ic += (icu_tick === 1'b1);
      aw += (awu_tick === 1'b1);
      foreach (pc[i]) pc[i] += (periph_tick[i] === 1'b1);
    end
    check_cnt(mt, n);
    check_cnt(ic, n);
    check_cnt(aw, 10);
    foreach (pc[i]) check_cnt(pc[i], en[i] ? n : 0);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    chk = 1'b0;
    ext_clock_mode = 1'b0;
    ext_stab_sel = 2'h1;
    failures = 0;
    tests_run = 0;
    seed = 32'h0913;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_SWITCH_REQ, {24'h0, CODE_RESET});
    rd(ADDR_MASTER_STATUS, {24'h0, CODE_RESET});
    rd(ADDR_SWITCH_CTRL, 32'h0);
    rd(ADDR_PCK_FIRST, {24'h0, PCK_FIRST_RESET});
    rd(ADDR_PCK_SECOND, {24'h0, PCK_SECOND_RESET});
    rd(8'h1c, 32'h0, 1'b1);
    repeat (20) @(posedge clk);
    rd(ADDR_INT_OSC, 32'h3);
    rd(ADDR_EXT_OSC, 32'h0);
    wr(ADDR_MASTER_STATUS, {24'h0, CODE_SLOW_INT});
    rd(ADDR_MASTER_STATUS, {24'h0, CODE_RESET});
    wr(ADDR_SWITCH_REQ, 32'h33);
    rd(ADDR_SWITCH_REQ, {24'h0, CODE_RESET});
    // Automatic switch to the slow internal source
    wr(ADDR_SWITCH_CTRL, F_EXEC);
    wr(ADDR_SWITCH_REQ, {24'h0, CODE_SLOW_INT});
    rd(ADDR_SWITCH_CTRL, F_BUSY | F_EXEC);
    wr(ADDR_SWITCH_REQ, {24'h0, CODE_FAST_EXT});
    rd(ADDR_SWITCH_REQ, {24'h0, CODE_SLOW_INT});
    poll(ADDR_MASTER_STATUS, 32'hff, {24'h0, CODE_SLOW_INT});
    rd(ADDR_SWITCH_CTRL, F_EXEC | F_DONE);
    rd(ADDR_INT_OSC, 32'hf);
    check_cnt({31'h0, switch_irq}, 32'h0);
    count_ticks(1'b0, '1);
    // Abort a pending switch, clearing busy while setting execute enable
    wr(ADDR_SWITCH_CTRL, 32'h0);
    wr(ADDR_SWITCH_REQ, {24'h0, CODE_FAST_EXT});
    wr(ADDR_SWITCH_CTRL, F_EXEC);
    rd(ADDR_SWITCH_REQ, {24'h0, CODE_SLOW_INT});
    rd(ADDR_SWITCH_CTRL, F_EXEC);
    rd(ADDR_MASTER_STATUS, {24'h0, CODE_SLOW_INT});
    rd(ADDR_EXT_OSC, 32'h1);
    count_ticks(1'b0, '1);
    rd(ADDR_EXT_OSC, 32'h3);
    // Manual switch to the external source with the interrupt enabled
    wr(ADDR_SWITCH_CTRL, F_IRQEN);
    wr(ADDR_SWITCH_REQ, {24'h0, CODE_FAST_EXT});
    poll(ADDR_SWITCH_CTRL, F_DONE, F_DONE);
    rd(ADDR_SWITCH_CTRL, F_BUSY | F_IRQEN | F_DONE);
    rd(ADDR_MASTER_STATUS, {24'h0, CODE_SLOW_INT});
    check_cnt({31'h0, switch_irq}, 32'h1);
    count_ticks(1'b0, '1);
    // Busy is written back as one: a zero there would abort the switch
    wr(ADDR_SWITCH_CTRL, F_BUSY | F_EXEC | F_IRQEN);
    poll(ADDR_MASTER_STATUS, 32'hff, {24'h0, CODE_FAST_EXT});
    rd(ADDR_SWITCH_CTRL, F_EXEC | F_IRQEN | F_DONE);
    check_cnt({31'h0, switch_irq}, 32'h1);
    rd(ADDR_INT_OSC, 32'hf);
    // Random gating patterns on the external master source
    repeat (3)
    begin
      v = $random(seed);
      // No peripheral logic sits behind these gates, so none is stopped first
      wr(ADDR_PCK_FIRST, {24'h0, v[7:0]});
      wr(ADDR_PCK_SECOND, {24'h0, v[15:8]});
      rd(ADDR_PCK_FIRST, {24'h0, v[7:0] & 8'h7f});
      rd(ADDR_PCK_SECOND, {24'h0, v[15:8] & 8'h3f});
      count_ticks(1'b1, {v[13:8], v[6:0]});
    end
    final_report();
  end
endmodule
